// ===== design/hmp_pkg.sv
package hmp_pkg;

  // ==========================================================================
  // Widths and register map.
  // ==========================================================================
  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  // Address of the overlay control register on the port.
  localparam logic [15:0] OVERLAY_CTRL_ADDR = 16'h3fe7;
  // Position of the short-read-only enable bit.
  localparam int SRO_BIT = 14;
  localparam logic SRO_RESET = 1'b0;

  // ==========================================================================
  // Timing, in ns at a 100 MHz clock.
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  // The acknowledge must rise within this time of a read starting.
  localparam int ACK_HIGH_MAX_NS = 10;
  localparam int ACK_HIGH_CYC = (ACK_HIGH_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                ACK_HIGH_MAX_NS / CLK_PERIOD_NS;
  // Least read pulse the host gives.
  localparam int READ_MIN_NS = 10;
  localparam int READ_MIN_CYC = (READ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Drivers must be released within this time of a read ending.
  localparam int DISABLE_MAX_NS = 10;
  localparam int DISABLE_CYC = (DISABLE_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                               DISABLE_MAX_NS / CLK_PERIOD_NS;
  // Internal memory fetch latency, in cycles.
  localparam int FETCH_CYC = 2;

  // Host command kinds.
  typedef enum logic [1:0] {
    HMP_CMD_SHORT = 2'h0,
    HMP_CMD_LONG  = 2'h1,
    HMP_CMD_WCFG  = 2'h2
  } hmp_cmd_t;

endpackage

// ===== design/hmp_if.sv
`timescale 1ns/100ps
// Pins of the host memory-access port, joined between both ends.
interface hmp_if;
  logic host_port_select_n;
  logic host_read_strobe_n;
  logic host_write_strobe_n;
  logic host_transfer_ack_n;
  logic [15:0] bus_dev_o;
  logic bus_dev_oe;
  logic [15:0] bus_host_o;
  logic bus_host_oe;
  logic [15:0] host_addr_data_bus;

  // Resolve the shared bus from the two enables.
  assign host_addr_data_bus = bus_dev_oe ? bus_dev_o : (bus_host_oe ? bus_host_o : 16'h0000);

  modport dev (
    input host_port_select_n, host_read_strobe_n, host_write_strobe_n, host_addr_data_bus,
    output host_transfer_ack_n, bus_dev_o, bus_dev_oe
  );
  modport host (
    output host_port_select_n, host_read_strobe_n, host_write_strobe_n, bus_host_o,
    bus_host_oe,
    input host_transfer_ack_n, host_addr_data_bus
  );
endinterface

// ===== design/hmp_device.sv
`timescale 1ns/100ps
// Contract
// [R1] Read runs while select and strobe both low.
// [R2] Host starts only with acknowledge low.
// [R3] Acknowledge high when busy, low when done.
// [R4] Short read drives previous word at once.
// [R5] Hold data, then release drivers after read.
// [R6] Plain short read pulse has bounded length.
// [R7] Program word is two halves; data one.
// [R8] Plain short reads only with mode cleared; the host issues them whatever the mode bit.
// [R9] Host should prefer short-read-only mode.
// [R10] Overlay bit 14 enables mode, resets zero.
// [R11] Core or host may write mode bit.
// [R12] Short-read-only holds data until read ends.
// [R13] Strap one selects host port pin functions; host writes to the overlay register are taken whatever the strap.
// [R14] Straps sampled at reset release, then held.
// [R15] Long read data valid before acknowledge low.
// [R16] Advance address and prefetch after each read.
module hmp_device #(
  parameter int ADDR_W = hmp_pkg::ADDR_W,
  parameter int DATA_W = hmp_pkg::DATA_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  hmp_if.dev port,
  input wire logic i_mode_strap,
  input wire logic i_core_wr,
  input wire logic [DATA_W-1:0] i_core_wdata,
  input wire logic i_pm_space,
  input wire logic [ADDR_W-1:0] i_start_addr,
  input wire logic i_start_load,
  output logic o_mem_req,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_second_half,
  input wire logic i_mem_valid,
  input wire logic [DATA_W-1:0] i_mem_data,
  output logic o_mem_ready,
  output logic o_host_mode,
  output logic o_short_read_only
);

  // ==========================================================================
  // Strap capture and overlay control.
  // ==========================================================================
  logic rst_d_r, rst_d_nxt;
  logic host_mode_r, host_mode_nxt;
  logic [DATA_W-1:0] overlay_r, overlay_nxt;
  logic host_cfg_wr;

  // Memory writes are not carried by this block, so every host write on the port goes to
  // the overlay control register; the bus then holds the data word, not the address.
  assign host_cfg_wr = !port.host_port_select_n && !port.host_write_strobe_n;

  // Strap caught on the first edge after reset is released, not under reset.
  always_comb begin
    rst_d_nxt = i_rst;
    host_mode_nxt = (rst_d_r && !i_rst) ? i_mode_strap : host_mode_r; // [R14]
    overlay_nxt = overlay_r;
    if (i_core_wr) begin
      overlay_nxt = i_core_wdata; // [R11]
    end else if (host_cfg_wr) begin
      overlay_nxt = port.host_addr_data_bus; // [R11]
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rst_d_r <= 1'b1;
      host_mode_r <= 1'b0;
      overlay_r <= '0; // [R10]
    end else begin
      rst_d_r <= rst_d_nxt;
      host_mode_r <= host_mode_nxt;
      overlay_r <= overlay_nxt;
    end
  end

  assign o_host_mode = host_mode_r; // [R13]
  assign o_short_read_only = overlay_r[hmp_pkg::SRO_BIT]; // [R10]

  // ==========================================================================
  // Two-entry prefetch buffer between memory and the port.
  // ==========================================================================
  logic [DATA_W-1:0] buf_r [2];
  logic [DATA_W-1:0] buf_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic buf_pop;

  assign o_mem_ready = (cnt_r != 2'h2);

  // The buffer stalls the fetch engine when full, so no word is lost.
  always_comb begin
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    if (buf_pop && cnt_r != 2'h0) begin
      buf_nxt[0] = buf_r[1];
      cnt_nxt = cnt_nxt - 2'h1;
    end
    if (i_mem_valid && o_mem_ready) begin
      buf_nxt[cnt_nxt[0]] = i_mem_data;
      cnt_nxt = cnt_nxt + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      buf_r <= '{default: '0};
      cnt_r <= 2'h0;
    end else begin
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================================
  // Read sequencer.
  // ==========================================================================
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SHORT = 5'h02,
    ST_LONG  = 5'h04,
    ST_HOLD  = 5'h08,
    ST_FETCH = 5'h10
  } hmp_state_t;

  hmp_state_t st_r, st_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic half_r, half_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic oe_r, oe_nxt;
  logic ack_n_r, ack_n_nxt;
  logic req_r, req_nxt;
  logic rd_active;

  assign rd_active = host_mode_r && !port.host_port_select_n &&
                     !port.host_read_strobe_n; // [R1]

  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    half_nxt = half_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    ack_n_nxt = ack_n_r;
    req_nxt = 1'b0;
    buf_pop = 1'b0;
    if (i_start_load) begin
      addr_nxt = i_start_addr;
      half_nxt = 1'b0;
    end
    case (st_r)
      ST_IDLE: begin
        oe_nxt = 1'b0;
        if (rd_active) begin
          ack_n_nxt = 1'b1; // [R3]
          oe_nxt = 1'b1; // [R4]
          dout_nxt = buf_r[0]; // [R4]
          if (cnt_r != 2'h0) begin
            buf_pop = 1'b1;
            st_nxt = ST_SHORT; // [R8] [R12]
          end else begin
            req_nxt = 1'b1;
            st_nxt = ST_LONG;
          end
        end
      end
      ST_LONG: begin
        if (cnt_r != 2'h0) begin
          dout_nxt = buf_r[0]; // [R15]
          buf_pop = 1'b1;
          st_nxt = ST_SHORT;
        end
      end
      ST_SHORT: begin
        if (!rd_active) begin
          // Drivers drop on the edge that sees the read end, so the bus is free a clock later.
          oe_nxt = 1'b0; // [R5]
          ack_n_nxt = 1'b1;
          st_nxt = ST_HOLD; // [R5] [R12]
        end else begin
          // Acknowledge falls one cycle after data is on the bus.
          ack_n_nxt = 1'b0; // [R3] [R15]
        end
      end
      ST_HOLD: begin
        oe_nxt = 1'b0; // [R5]
        ack_n_nxt = 1'b1;
        // Program words alternate halves; data words count as first halves.
        half_nxt = i_pm_space ? !half_r : 1'b0; // [R7]
        if (!i_pm_space || half_r) begin
          addr_nxt = addr_r + ADDR_W'(1); // [R16]
        end
        req_nxt = 1'b1; // [R16]
        st_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        // Stay busy until the next word has landed, so a short read after another read never finds the buffer
        // empty; the cost is a longer busy time when memory is slow.
        if (cnt_r != 2'h0) begin
          ack_n_nxt = 1'b0; // [R2] [R16]
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      addr_r <= '0;
      half_r <= 1'b0;
      dout_r <= '0;
      oe_r <= 1'b0;
      ack_n_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      half_r <= half_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      ack_n_r <= ack_n_nxt;
      req_r <= req_nxt;
    end
  end

  assign o_mem_req = req_r;
  assign o_mem_addr = addr_r;
  assign o_mem_second_half = half_r;
  assign port.bus_dev_o = dout_r;
  assign port.bus_dev_oe = oe_r;
  assign port.host_transfer_ack_n = ack_n_r;

endmodule

// ===== design/hmp_host.sv
`timescale 1ns/100ps
// ==========================================================================
// Host end: issues reads and overlay writes on the port pins.
// ==========================================================================
module hmp_host #(
  parameter int DATA_W = hmp_pkg::DATA_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  hmp_if.host port,
  input wire logic i_req_valid,
  input wire hmp_pkg::hmp_cmd_t i_req_cmd,
  input wire logic [DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_data
);

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_STRB = 4'h2,
    HS_WAIT = 4'h4,
    HS_DONE = 4'h8
  } hmp_hstate_t;

  hmp_hstate_t st_r, st_nxt;
  hmp_pkg::hmp_cmd_t cmd_r, cmd_nxt;
  logic sel_n_r, sel_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, oe_r, oe_nxt;
  logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic vld_r, vld_nxt;
  logic [1:0] cyc_r, cyc_nxt;

  // Requests are taken only while the device acknowledge is low. The response cycle is
  // skipped too: the device sees the read end only then and raises its busy flag after it.
  assign o_req_ready = (st_r == HS_IDLE) && !vld_r && !port.host_transfer_ack_n; // [R2]

  // Short reads are ended after a fixed two-cycle pulse, within the allowed window.
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    sel_n_nxt = sel_n_r;
    rd_n_nxt = rd_n_r;
    wr_n_nxt = wr_n_r;
    oe_nxt = oe_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    vld_nxt = 1'b0;
    cyc_nxt = cyc_r;
    case (st_r)
      HS_IDLE: begin
        if (i_req_valid && o_req_ready) begin
          cmd_nxt = i_req_cmd;
          sel_n_nxt = 1'b0; // [R1]
          cyc_nxt = 2'(hmp_pkg::READ_MIN_CYC); // [R6]
          if (i_req_cmd == hmp_pkg::HMP_CMD_WCFG) begin
            wr_n_nxt = 1'b0;
            oe_nxt = 1'b1;
            wd_nxt = i_req_wdata;
          end else begin
            rd_n_nxt = 1'b0; // [R1]
          end
          st_nxt = HS_STRB;
        end
      end
      HS_STRB: begin
        if (cyc_r > 2'h1) begin
          cyc_nxt = cyc_r - 2'h1;
        end else if (cmd_r == hmp_pkg::HMP_CMD_WCFG) begin
          st_nxt = HS_DONE;
        end else if (cmd_r == hmp_pkg::HMP_CMD_SHORT) begin
          // The device drives the word only from the edge at which it first sees the strobe low.
          st_nxt = HS_DONE;
        end else begin
          st_nxt = HS_WAIT;
        end
      end
      HS_WAIT: begin
        // Long read: sample at acknowledge low.
        if (!port.host_transfer_ack_n) begin
          rd_nxt = port.host_addr_data_bus; // [R15]
          st_nxt = HS_DONE;
        end
      end
      HS_DONE: begin
        if (cmd_r == hmp_pkg::HMP_CMD_SHORT) begin
          rd_nxt = port.host_addr_data_bus; // [R4] [R9]
        end
        sel_n_nxt = 1'b1; // [R1]
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        oe_nxt = 1'b0;
        vld_nxt = (cmd_r != hmp_pkg::HMP_CMD_WCFG);
        st_nxt = HS_IDLE;
      end
      default: begin
        st_nxt = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= HS_IDLE;
      cmd_r <= hmp_pkg::HMP_CMD_SHORT;
      sel_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      oe_r <= 1'b0;
      wd_r <= '0;
      rd_r <= '0;
      vld_r <= 1'b0;
      cyc_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      sel_n_r <= sel_n_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      oe_r <= oe_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      vld_r <= vld_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  assign port.host_port_select_n = sel_n_r;
  assign port.host_read_strobe_n = rd_n_r;
  assign port.host_write_strobe_n = wr_n_r;
  assign port.bus_host_o = wd_r;
  assign port.bus_host_oe = oe_r;
  assign o_rsp_valid = vld_r;
  assign o_rsp_data = rd_r;

endmodule

// ===== test/hmp_sva.sv
`timescale 1ns/100ps
// ==========================================================================
// Pin checker for the port between host and device.
// ==========================================================================
module hmp_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic host_port_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_transfer_ack_n,
  input wire logic [15:0] bus_dev_o,
  input wire logic bus_dev_oe,
  input wire logic bus_host_oe
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  logic rd;
  // A read is under way only while select and strobe are both low.
  assign rd = !host_port_select_n && !host_read_strobe_n;
  property p_start;
    rd && !$past(rd) |=> host_transfer_ack_n && bus_dev_oe;
  endproperty
  a_start: assert property (p_start) else $error("no busy or drive after read start");
  property p_free;
    rd && !$past(rd) |-> !$past(host_transfer_ack_n);
  endproperty
  a_free: assert property (p_free) else $error("read began while port busy");
  property p_cause;
    bus_dev_oe |-> $past(rd);
  endproperty
  a_cause: assert property (p_cause) else $error("device drives bus outside a read");
  // The release is bounded so a stuck prefetch shows up as a failure.
  property p_release;
    !rd && $past(rd) |=> (!bus_dev_oe && host_transfer_ack_n) ##[1:20] !host_transfer_ack_n;
  endproperty
  a_release: assert property (p_release) else $error("bad release after read");
  property p_hold;
    bus_dev_oe && !host_transfer_ack_n ##1 bus_dev_oe |-> $stable(bus_dev_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved before read end");
  property p_busy;
    $rose(host_transfer_ack_n) |-> ##[1:40] !host_transfer_ack_n;
  endproperty
  a_busy: assert property (p_busy) else $error("acknowledge stuck busy");
  property p_clash;
    !(bus_dev_oe && bus_host_oe);
  endproperty
  a_clash: assert property (p_clash) else $error("both ends drive the bus");
  property p_setup;
    $fell(host_transfer_ack_n) && bus_dev_oe |-> $past(bus_dev_oe);
  endproperty
  a_setup: assert property (p_setup) else $error("data not set up before ack low");
  c_read: cover property (rd && !$past(rd));
  c_write: cover property ($fell(host_write_strobe_n));
  c_long: cover property (host_transfer_ack_n [*3]);
endmodule

// ===== test/test_host_dma_read_port.sv
`timescale 1ns/100ps
// ==========================================================================
// Bench: host end reads from device end, memory answers with stalls.
// ==========================================================================
module test_host_dma_read_port;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic strap = 1'b0, core_wr = 1'b0, pm = 1'b0, load = 1'b0;
  logic mem_valid = 1'b0, req_valid = 1'b0, seen = 1'b0, rdy_s = 1'b0;
  logic [15:0] core_wdata = 16'h0000, mem_data = 16'h0000, req_wdata = 16'h0000;
  logic [13:0] start_addr = 14'h0000;
  hmp_pkg::hmp_cmd_t req_cmd = hmp_pkg::HMP_CMD_SHORT;
  logic mem_req, mem_half, mem_ready, host_mode, sro, req_ready, rsp_valid, eh;
  logic [13:0] mem_addr, ea;
  logic [15:0] rsp_data;
  logic [15:0] exp_q[$], pend_q[$];
  int miscompares = 0, comparisons = 0, wt = 0;
  logic fresh = 1'b0;
  hmp_if bus ();
  hmp_device i_hmp_device (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .port(bus),
    .i_mode_strap(strap), .i_core_wr(core_wr), .i_core_wdata(core_wdata), .i_pm_space(pm),
    .i_start_addr(start_addr), .i_start_load(load), .o_mem_req(mem_req),
    .o_mem_addr(mem_addr), .o_mem_second_half(mem_half), .i_mem_valid(mem_valid),
    .i_mem_data(mem_data), .o_mem_ready(mem_ready), .o_host_mode(host_mode),
    .o_short_read_only(sro));
  hmp_host i_hmp_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .port(bus),
    .i_req_valid(req_valid), .i_req_cmd(req_cmd), .i_req_wdata(req_wdata),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));
  hmp_sva i_hmp_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .host_port_select_n(bus.host_port_select_n), .host_read_strobe_n(bus.host_read_strobe_n),
    .host_write_strobe_n(bus.host_write_strobe_n),
    .host_transfer_ack_n(bus.host_transfer_ack_n), .bus_dev_o(bus.bus_dev_o),
    .bus_dev_oe(bus.bus_dev_oe), .bus_host_oe(bus.bus_host_oe));

  // The clock runs at 100 MHz.
  always #5 i_clk_sys = ~i_clk_sys;

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic finish_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ========================================================================
  // Memory model and monitors.
  // ========================================================================
  // Memory words encode half and address, so a wrong fetch shows in the data.
  always @(negedge i_clk_sys) begin
    rdy_s = mem_ready;
    if (mem_req === 1'b1) pend_q.push_back({mem_half, 1'b0, mem_addr});
    if (bus.bus_dev_oe === 1'b1 && bus.host_transfer_ack_n === 1'b0 && !seen) begin
      chk16(bus.host_addr_data_bus, exp_q.size() > 0 ? exp_q[$] : 16'hxxxx);
      seen = 1'b1;
    end
    if (bus.bus_dev_oe !== 1'b1) seen = 1'b0;
    if (rsp_valid === 1'b1) chk16(rsp_data, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
  end
  // A random wait of up to three cycles varies the fetch time, yet stays bounded so that
  // the busy time of the port keeps within the checker's limits.
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      mem_valid <= 1'b0;
      pend_q.delete();
    end else if (mem_valid && rdy_s) mem_valid <= 1'b0;
    else if (!mem_valid && pend_q.size() > 0) begin
      if (wt == 0) begin
        mem_valid <= 1'b1;
        mem_data <= pend_q.pop_front();
        wt <= $urandom_range(3);
      end else wt <= wt - 1;
    end
  end

  // ========================================================================
  // Stimulus.
  // ========================================================================
  task automatic do_reset(input logic s);
    i_rst <= 1'b1;
    strap <= s;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask
  // Valid stays up between requests, so back-to-back requests need no gap.
  task automatic send(input hmp_pkg::hmp_cmd_t c, input logic [15:0] w);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_wdata <= w;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) miscompares++;
    @(posedge i_clk_sys);
    if (c != hmp_pkg::HMP_CMD_WCFG) begin
      exp_q.push_back({eh, 1'b0, ea});
      if (!pm || eh) ea = ea + 14'h0001;
      if (pm) eh = !eh;
    end
  endtask
  task automatic reads(input int k);
    int n;
    n = 0;
    // Nothing is prefetched for a new address yet, so its first read must be a long one.
    repeat (k) begin
      send(fresh ? hmp_pkg::HMP_CMD_LONG : hmp_pkg::hmp_cmd_t'($urandom_range(1)), 16'h0000);
      fresh = 1'b0;
    end
    req_valid <= 1'b0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (exp_q.size() > 0 && n < 500);
    chk16(16'(exp_q.size()), 16'h0000);
  endtask
  task automatic load_addr(input logic p, input logic [13:0] a);
    pm <= p;
    start_addr <= a;
    load <= 1'b1;
    @(posedge i_clk_sys);
    load <= 1'b0;
    ea = a;
    eh = 1'b0;
    fresh = 1'b1;
  endtask
  task automatic wait_sro(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (sro !== v && n < 20);
    chk1(sro, v);
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'hc347));
    do_reset(1'b0);
    chk1(host_mode, 1'b0);
    strap <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    chk1(host_mode, 1'b0);
    $display("test strap done");
    do_reset(1'b1);
    chk1(host_mode, 1'b1);
    chk1(sro, 1'b0);
    load_addr(1'b0, 14'h0100);
    reads(12);
    $display("test data reads done");
    send(hmp_pkg::HMP_CMD_WCFG, 16'($urandom) | 16'h4000);
    req_valid <= 1'b0;
    wait_sro(1'b1);
    reads(8);
    core_wr <= 1'b1;
    core_wdata <= 16'($urandom) & 16'hbfff;
    @(posedge i_clk_sys);
    core_wr <= 1'b0;
    wait_sro(1'b0);
    reads(4);
    $display("test overlay done");
    do_reset(1'b1);
    load_addr(1'b1, 14'h3ffe);
    reads(8);
    $display("test program reads done");
    finish_test();
  end

  // Fewer than 1000 cycles are needed; the limit allows 30000.
  initial begin
    #300000;
    miscompares++;
    finish_test();
  end
endmodule
